// *** src/acf_defs.vh ***
// Register map, field positions and reset values for the calibration and result queue block
`ifndef ACF_DEFS_VH
`define ACF_DEFS_VH
`define ACF_REG_SOFF 8'h10
`define ACF_REG_SGAIN 8'h11
`define ACF_REG_ODIR 8'h12
`define ACF_REG_QHEAD 8'h13
`define ACF_LEN_TRIM 3'h3
`define ACF_LEN_ODIR 3'h1
`define ACF_LEN_QHEAD 3'h4
`define ACF_LEN_NONE 3'h1
`define ACF_SOFF_RST 24'h000000
`define ACF_SGAIN_RST 24'hBF851B
`define ACF_ODIR_RST 8'h00
`define ACF_QHEAD_RST 32'h00000000
`define ACF_BIT_OVW 31
`define ACF_CH_MSB 27
`define ACF_CH_LSB 25
`define ACF_BIT_OOR 24
`define ACF_Q_DEPTH 7'h40
`define ACF_Q_AW 6
`define ACF_BUF_DEPTH 8
`define ACF_BUF_AW 3
`define ACF_WORD_W 32
`define ACF_GAIN_FRAC 23
`define ACF_MODE_A 3'h3
`define ACF_MODE_B 3'h4
// Arbitrary serial slave address
`define ACF_SLV_ADDR 7'h30
`endif

// *** src/acf_fifo.v ***
// Small valid/ready FIFO in front of the result queue
`timescale 1ns/100ps
`default_nettype none
module acf_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire in_valid, // Word offered
  output wire in_ready, // Space free
  input wire [W-1:0] in_data, // Word in
  output wire out_valid, // Word held
  input wire out_ready, // Drain accepts
  output wire [W-1:0] out_data // Oldest word
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  // Full and empty straight from the count
  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/acf_ram.v ***
// Result queue storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module acf_ram #(
  parameter W = 32,
  parameter D = 64,
  parameter AW = 6
) (
  input wire clk, // System clock
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write address
  input wire [W-1:0] wdata, // Write data
  input wire [AW-1:0] raddr, // Read address
  output reg [W-1:0] rdata // Read data, one cycle late
);
  reg [W-1:0] mem [0:D-1];

  // One write port, one registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// *** src/acf_top.v ***
// Calibration trims, direct outputs and tagged result queue behind the serial port
`timescale 1ns/100ps
`default_nettype none
`include "acf_defs.vh"
module acf_top (
  input wire clk_sys, // 40 MHz system clock
  input wire rst, // Synchronous reset, high
  input wire scl_in, // Serial clock pin
  input wire sda_in, // Serial data pin level
  output reg sda_out, // Serial data drive value
  output reg sda_oe, // Serial data pull-low enable
  input wire conv_valid, // Raw conversion offered
  output reg conv_ready, // Conversion path can take one
  input wire [23:0] conv_data, // Raw result, two's complement
  input wire [2:0] conv_ch, // Channel of the result
  input wire [23:0] lower_bound, // Lower limit of that channel
  input wire [23:0] upper_bound, // Upper limit of that channel
  input wire [23:0] sys_offset, // System offset trim
  input wire [23:0] sys_gain, // System gain trim
  input wire skip_self_offset, // Bypass self offset
  input wire skip_self_gain, // Bypass self gain
  input wire skip_system_offset, // Bypass system offset
  input wire skip_system_gain, // Bypass system gain
  input wire unipolar, // Unipolar input range
  input wire format_offset_bin, // Bipolar coding select
  input wire cal_readback_select, // Trim readback select
  input wire [2:0] seq_mode, // Sequencer mode 1..4
  input wire sleep, // Sleep power state
  input wire self_cal_busy, // Self-calibration running
  input wire cal_store, // Self-calibration result strobe
  input wire [23:0] cal_offset_new, // Computed offset
  input wire [23:0] cal_gain_new, // Computed gain
  output reg [5:0] general_output, // Direct output pins
  output reg [6:0] fifo_level // Entries held in the queue
);
  localparam [8:0] S_IDLE = 9'h001, S_ADDR = 9'h002, S_AACK = 9'h004, S_REG = 9'h008;
  localparam [8:0] S_RACK = 9'h010, S_WR = 9'h020, S_WACK = 9'h040, S_RD = 9'h080;
  localparam [8:0] S_MACK = 9'h100, S_SHIFT_IN = 9'h02A;
  reg [2:0] scl_s_r, sda_s_r;
  reg [8:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r, reg_addr_r, wr_addr_r, odir_r;
  reg rw_r, mack_r, wr_pulse_r, pop_req_r, stage_v_r;
  reg [1:0] bidx_r;
  reg [23:0] wbuf_r, wr_data_r, soff_r, sgain_r, int_off_r, int_gain_r;
  reg [31:0] word_r, stage_w_r, rd_val;
  reg [5:0] wp_r, rp_r;
  reg [2:0] cur_len;
  wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
  wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
  wire start = scl_s_r[1] & ~sda_s_r[1] & sda_s_r[2];
  wire stop = scl_s_r[1] & sda_s_r[1] & ~sda_s_r[2];
  wire last_byte = ({1'b0, bidx_r} + 3'h1) == cur_len;
  wire mode_locked = (seq_mode == `ACF_MODE_A) | (seq_mode == `ACF_MODE_B);
  // Pin synchronisers plus one stage for edge finding
  always @(posedge clk_sys) begin
    if (rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
    end
  end
  // Register length in bytes on the serial port
  always @* begin
    case (reg_addr_r)
      `ACF_REG_SOFF: cur_len = `ACF_LEN_TRIM;
      `ACF_REG_SGAIN: cur_len = `ACF_LEN_TRIM;
      `ACF_REG_ODIR: cur_len = `ACF_LEN_ODIR;
      `ACF_REG_QHEAD: cur_len = `ACF_LEN_QHEAD;
      default: cur_len = `ACF_LEN_NONE;
    endcase
  end
  // Read value, left aligned so it leaves MSB first
  wire [31:0] head_w;
  always @* begin
    case (reg_addr_r)
      `ACF_REG_SOFF: rd_val = {(cal_readback_select ? soff_r : int_off_r), 8'h00};
      `ACF_REG_SGAIN: rd_val = {(cal_readback_select ? sgain_r : int_gain_r), 8'h00};
      `ACF_REG_ODIR: rd_val = {odir_r, 24'h000000};
      `ACF_REG_QHEAD: rd_val = head_w;
      default: rd_val = 32'h00000000;
    endcase
  end
  // Serial slave: address, register pointer, data bytes
  always @(posedge clk_sys) begin
    if (rst) begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      reg_addr_r <= 8'h00;
      bidx_r <= 2'h0;
      wbuf_r <= 24'h000000;
      word_r <= 32'h00000000;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_pulse_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 24'h000000;
      pop_req_r <= 1'b0;
    end else begin
      wr_pulse_r <= 1'b0;
      pop_req_r <= 1'b0;
      if (start) begin
        st_r <= S_ADDR;
        cnt_r <= 4'h0;
        bidx_r <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_r <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (((st_r & S_SHIFT_IN) != 9'h000) && (cnt_r != 4'h8)) begin
          sh_r <= {sh_r[6:0], sda_s_r[1]};
          cnt_r <= cnt_r + 4'h1;
        end
        if (st_r == S_MACK)
          mack_r <= ~sda_s_r[1];
      end else if (scl_fall) begin
        case (st_r)
          S_ADDR: begin
            if (cnt_r == 4'h8) begin
              if (sh_r[7:1] == `ACF_SLV_ADDR) begin
                st_r <= S_AACK;
                sda_oe <= 1'b1;
                rw_r <= sh_r[0];
              end else begin
                st_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (rw_r) begin
              st_r <= S_RD;
              bidx_r <= 2'h0;
              word_r <= {rd_val[30:0], 1'b0};
              sda_oe <= ~rd_val[31];
              cnt_r <= 4'h1;
            end else begin
              st_r <= S_REG;
              sda_oe <= 1'b0;
              cnt_r <= 4'h0;
            end
          end
          S_REG: begin
            if (cnt_r == 4'h8) begin
              reg_addr_r <= sh_r;
              bidx_r <= 2'h0;
              st_r <= S_RACK;
              sda_oe <= 1'b1;
            end
          end
          S_RACK: begin
            st_r <= S_WR;
            sda_oe <= 1'b0;
            cnt_r <= 4'h0;
          end
          S_WR: begin
            if (cnt_r == 4'h8) begin
              wbuf_r <= {wbuf_r[15:0], sh_r};
              st_r <= S_WACK;
              sda_oe <= 1'b1;
              if (last_byte) begin
                wr_pulse_r <= 1'b1;
                wr_addr_r <= reg_addr_r;
                wr_data_r <= {wbuf_r[15:0], sh_r};
                reg_addr_r <= reg_addr_r + 8'h01;
                bidx_r <= 2'h0;
              end else begin
                bidx_r <= bidx_r + 2'h1;
              end
            end
          end
          S_WACK: begin
            st_r <= S_WR;
            sda_oe <= 1'b0;
            cnt_r <= 4'h0;
          end
          S_RD: begin
            if (cnt_r != 4'h8) begin
              sda_oe <= ~word_r[31];
              word_r <= {word_r[30:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end else begin
              sda_oe <= 1'b0;
              st_r <= S_MACK;
              if (last_byte) begin
                bidx_r <= 2'h0;
                reg_addr_r <= reg_addr_r + 8'h01;
                pop_req_r <= (reg_addr_r == `ACF_REG_QHEAD);
              end else begin
                bidx_r <= bidx_r + 2'h1;
              end
            end
          end
          S_MACK: begin
            if (mack_r) begin
              st_r <= S_RD;
              cnt_r <= 4'h1;
              if (bidx_r == 2'h0) begin
                word_r <= {rd_val[30:0], 1'b0};
                sda_oe <= ~rd_val[31];
              end else begin
                word_r <= {word_r[30:0], 1'b0};
                sda_oe <= ~word_r[31];
              end
            end else begin
              st_r <= S_IDLE;
              sda_oe <= 1'b0;
            end
          end
          default: begin
            st_r <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  // Trim, direct output and internal calibration storage
  always @(posedge clk_sys) begin
    if (rst) begin
      soff_r <= `ACF_SOFF_RST;
      sgain_r <= `ACF_SGAIN_RST;
      odir_r <= `ACF_ODIR_RST;
      int_off_r <= `ACF_SOFF_RST;
      int_gain_r <= `ACF_SGAIN_RST;
      general_output <= 6'h00;
    end else begin
      if (wr_pulse_r) begin
        case (wr_addr_r)
          `ACF_REG_SOFF: begin
            if (!self_cal_busy)
              soff_r <= wr_data_r;
          end
          `ACF_REG_SGAIN: begin
            if (!self_cal_busy)
              sgain_r <= wr_data_r;
          end
          `ACF_REG_ODIR: begin
            if (!mode_locked)
              odir_r <= wr_data_r[7:0];
          end
          default: begin
            odir_r <= odir_r;
          end
        endcase
      end
      if (cal_store) begin
        int_off_r <= cal_offset_new;
        int_gain_r <= cal_gain_new;
      end
      // Register drives pins in every mode, calibrations included, except sleep, which holds them at zero
      general_output <= sleep ? 6'h00 : odir_r[5:0];
    end
  end
  // Correction chain, one combinational pass per conversion
  wire signed [27:0] x0 = {{4{conv_data[23]}}, conv_data};
  wire signed [27:0] so = {{4{soff_r[23]}}, soff_r};
  wire signed [27:0] x1 = skip_self_offset ? x0 : x0 - so;
  wire signed [27:0] g1 = {4'h0, sgain_r};
  wire signed [55:0] p1 = x1 * g1;
  // 23 fraction bits keep rounding error well under 2 LSB
  wire signed [27:0] x2 = skip_self_gain ? x1 : p1[50:23];
  wire signed [27:0] yo = {{4{sys_offset[23]}}, sys_offset};
  wire signed [27:0] x3 = skip_system_offset ? x2 : x2 - yo;
  wire signed [27:0] g2 = {4'h0, sys_gain};
  wire signed [55:0] p2 = x3 * g2;
  wire signed [27:0] x4 = skip_system_gain ? x3 : p2[50:23];
  wire [28:0] x5 = unipolar ? {x4, 1'b0} : {x4[27], x4};
  wire in_span = (x5[28:23] == 6'h00) | (x5[28:23] == 6'h3F);
  wire [23:0] clamped = in_span ? x5[23:0] : (x5[28] ? 24'h800000 : 24'h7FFFFF);
  wire to_ofs_bin = unipolar | format_offset_bin;
  wire [23:0] coded = {clamped[23] ^ to_ofs_bin, clamped[22:0]};
  wire out_of_range_flag = ($signed(clamped) < $signed(lower_bound)) |
    ($signed(clamped) > $signed(upper_bound));
  wire [31:0] entry_w = {1'b0, 3'h0, conv_ch, out_of_range_flag, coded};
  // Holding stage ahead of the buffer; stalls the converter
  wire buf_in_ready, buf_out_valid;
  wire [31:0] buf_out_data, ram_q;
  wire accept = conv_valid & conv_ready;
  always @(posedge clk_sys) begin
    if (rst) begin
      stage_v_r <= 1'b0;
      stage_w_r <= 32'h00000000;
      conv_ready <= 1'b0;
    end else begin
      if (accept) begin
        stage_v_r <= 1'b1;
        stage_w_r <= entry_w;
      end else if (buf_in_ready) begin
        stage_v_r <= 1'b0;
      end
      conv_ready <= ~(accept | (stage_v_r & ~buf_in_ready));
    end
  end
  wire buf_out_ready = ~pop_req_r;
  acf_fifo #(.W(`ACF_WORD_W), .D(`ACF_BUF_DEPTH), .AW(`ACF_BUF_AW)) u_buf (
    .clk(clk_sys),
    .rst(rst),
    .in_valid(stage_v_r),
    .in_ready(buf_in_ready),
    .in_data(stage_w_r),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );
  // Ring of 64 entries; when full the newest replaces the oldest
  wire push = buf_out_valid & buf_out_ready;
  wire q_full = (fifo_level == `ACF_Q_DEPTH);
  wire pop = pop_req_r & (fifo_level != 7'h00);
  wire [31:0] push_w = {q_full, buf_out_data[30:0]};
  always @(posedge clk_sys) begin
    if (rst) begin
      wp_r <= 6'h00;
      rp_r <= 6'h00;
      fifo_level <= 7'h00;
    end else if (push) begin
      wp_r <= wp_r + 6'h01;
      if (q_full)
        rp_r <= rp_r + 6'h01;
      else
        fifo_level <= fifo_level + 7'h01;
    end else if (pop) begin
      rp_r <= rp_r + 6'h01;
      fifo_level <= fifo_level - 7'h01;
    end
  end
  acf_ram #(.W(`ACF_WORD_W), .D(`ACF_Q_DEPTH), .AW(`ACF_Q_AW)) u_ram (
    .clk(clk_sys),
    .we(push),
    .waddr(wp_r),
    .wdata(push_w),
    .raddr(rp_r),
    .rdata(ram_q)
  );
  // Empty queue reads as the reset word
  assign head_w = (fifo_level == 7'h00) ? `ACF_QHEAD_RST : ram_q;
endmodule
`default_nettype wire

// *** tb/acf_host_model.sv ***
// Serial register host: start, stop, bytes and register accesses
`timescale 1ns/100ps
`default_nettype none
`include "acf_defs.vh"
module acf_host_model (
  input wire logic clk, // Pacing clock
  input wire logic sda, // Resolved data line
  output logic scl, // Serial clock, idle high
  output logic sda_low // Pulls data low
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of a 200 ns serial period
  task automatic q;
    repeat (2) @(posedge clk);
  endtask
  // Start or repeated start
  task automatic start;
    sda_low <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask
  // One bit: drive b, sample the line mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    q;
    scl <= 1'b1;
    q;
    s = sda;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic put(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    if (s) nacks++;
  endtask
  task automatic get(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(last, s);
  endtask
  // Register write of n bytes, most significant first
  task automatic wr(input logic [7:0] ra, input logic [31:0] d, input int n);
    start;
    put({`ACF_SLV_ADDR, 1'b0});
    put(ra);
    for (int i = n - 1; i >= 0; i--) put(d[8*i+:8]);
    stop;
  endtask
  // Register read with repeated start, last byte not acknowledged
  task automatic rd(input logic [7:0] ra, input int n, output logic [31:0] d);
    logic [7:0] v;
    d = 32'h00000000;
    start;
    put({`ACF_SLV_ADDR, 1'b0});
    put(ra);
    start;
    put({`ACF_SLV_ADDR, 1'b1});
    for (int i = n - 1; i >= 0; i--) begin
      get(i == 0, v);
      d[8*i+:8] = v;
    end
    stop;
  endtask
endmodule
`default_nettype wire

// *** tb/acf_top_assertions.sv ***
// Port-level checker for the calibration and result queue block
`timescale 1ns/100ps
`default_nettype none
module acf_top_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe, // Data pull-low enable
  input wire logic conv_valid, // Conversion offered
  input wire logic conv_ready, // Conversion taken
  input wire logic [2:0] seq_mode, // Sequencer mode
  input wire logic sleep, // Sleep state
  input wire logic [5:0] general_output, // Output pins
  input wire logic [6:0] fifo_level // Queue count
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Steps shared by the properties
  sequence s_accept;
    conv_valid && conv_ready;
  endsequence
  sequence s_locked;
    (seq_mode == 3'h3 || seq_mode == 3'h4) && !sleep;
  endsequence
  // Outputs quiet after reset
  property p_reset;
    disable iff (1'b0) rst |=> !sda_oe && !conv_ready && general_output == 6'h00
      && fifo_level == 7'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_sleep;
    sleep |=> general_output == 6'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("outputs on in sleep");
  property p_wake;
    general_output != $past(general_output) && general_output != 6'h00 |-> !$past(sleep);
  endproperty
  a_wake: assert property (p_wake) else $error("outputs rose in sleep");
  // Locked modes outside sleep freeze the pins
  property p_lock;
    s_locked [*3] |-> $stable(general_output);
  endproperty
  a_lock: assert property (p_lock) else $error("outputs moved in locked mode");
  property p_max;
    fifo_level <= 7'h40;
  endproperty
  a_max: assert property (p_max) else $error("queue level above 64");
  property p_step;
    fifo_level == $past(fifo_level) || fifo_level == $past(fifo_level) + 7'h01
      || fifo_level == $past(fifo_level) - 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("queue level jumped");
  property p_gap;
    s_accept |=> !conv_ready;
  endproperty
  a_gap: assert property (p_gap) else $error("ready stayed high after accept");
  property p_sda;
    sda_out == 1'b0;
  endproperty
  a_sda: assert property (p_sda) else $error("data line driven high");
endmodule
bind acf_top acf_top_chk u_chk (.clk_sys, .rst, .sda_out, .sda_oe, .conv_valid, .conv_ready,
  .seq_mode, .sleep, .general_output, .fifo_level);
`default_nettype wire

// *** tb/acf_top_bench.sv ***
// Self-checking bench: trims, correction path, direct outputs, result queue
`timescale 1ns/100ps
`default_nettype none
`include "acf_defs.vh"
module acf_top_bench;
  logic clk_sys = 1'b0, rst = 1'b1, conv_valid = 1'b0, cal_store = 1'b0, sleep = 1'b0;
  logic skip_self_offset = 1'b1, skip_self_gain = 1'b1, skip_system_offset = 1'b1;
  logic unipolar = 1'b0, fmt = 1'b0, cal_readback_select = 1'b1, self_cal_busy = 1'b0;
  logic skip_system_gain = 1'b1;
  logic [2:0] conv_ch = 3'h0, seq_mode = 3'h1;
  logic [23:0] conv_data = 24'h000000, sys_offset = 24'h000008, sys_gain = 24'h400000;
  logic [23:0] cal_offset_new = 24'h000000, cal_gain_new = 24'h000000;
  logic sda_out, sda_oe, conv_ready, scl, host_low;
  logic [5:0] general_output;
  logic [6:0] fifo_level;
  wire logic sda_line;
  int err_count = 0, tests_run = 0;
  logic [4:0] t_ctl [8] = '{5'h01, 5'h01, 5'h05, 5'h00, 5'h01, 5'h01, 5'h0F, 5'h17};
  logic [23:0] t_gain [8] = '{24'h800000, 24'hC00000, 24'hC00000, 24'hC00000,
    24'hC00000, 24'hC00000, 24'hC00000, 24'hC00000};
  logic [23:0] t_in [8] = '{24'h000100, 24'h000110, 24'h000110, 24'h000110,
    24'h7FFFF0, 24'h800000, 24'h000000, 24'h000100};
  logic [23:0] t_res [8] = '{24'h0000F0, 24'h000180, 24'h000198, 24'h000178,
    24'h7FFFFF, 24'h800000, 24'h800000, 24'h800200};
  logic [7:0] t_oor = 8'h30;
  // Open-drain data line with pull-up
  assign sda_line = !(host_low | sda_oe);
  always #12.5 clk_sys = ~clk_sys;
  acf_top uut (.clk_sys, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .conv_valid, .conv_ready, .conv_data, .conv_ch, .lower_bound(24'h000000),
    .upper_bound(24'h001000), .sys_offset, .sys_gain, .skip_self_offset,
    .skip_self_gain, .skip_system_offset, .skip_system_gain, .unipolar,
    .format_offset_bin(fmt), .cal_readback_select, .seq_mode, .sleep, .self_cal_busy,
    .cal_store, .cal_offset_new, .cal_gain_new, .general_output, .fifo_level);
  acf_host_model host (.clk(clk_sys), .sda(sda_line), .scl(scl), .sda_low(host_low));
  // Comparison and verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdc(input string nm, input logic [7:0] ra, input int n, input logic [31:0] e);
    logic [31:0] d;
    host.rd(ra, n, d);
    check(nm, d, e);
  endtask
  task automatic out_is(input logic [5:0] e);
    check("general_output", {26'h0, general_output}, {26'h0, e});
  endtask
  task automatic reset_dut;
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Offer one conversion and hold it until taken
  task automatic conv(input logic [23:0] d, input logic [2:0] ch);
    int k;
    @(posedge clk_sys);
    conv_data <= d;
    conv_ch <= ch;
    conv_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!conv_ready && k < 50);
    conv_valid <= 1'b0;
    if (k >= 50) check("conv_ready", 32'h0, 32'h1);
  endtask
  // Main sequence
  initial begin
    reset_dut;
    rdc("offset reset", `ACF_REG_SOFF, 3, 32'h000000);
    rdc("gain reset", `ACF_REG_SGAIN, 3, 32'hBF851B);
    rdc("direct reset", `ACF_REG_ODIR, 1, 32'h00);
    rdc("queue empty", `ACF_REG_QHEAD, 4, 32'h0);
    $display("test reset values done");
    host.wr(`ACF_REG_SOFF, 32'h123456, 3);
    host.wr(`ACF_REG_SGAIN, 32'h89ABCD, 3);
    self_cal_busy <= 1'b1;
    host.wr(`ACF_REG_SOFF, 32'hABCDEF, 3);
    host.wr(`ACF_REG_SGAIN, 32'h111111, 3);
    self_cal_busy <= 1'b0;
    rdc("offset trim", `ACF_REG_SOFF, 3, 32'h123456);
    rdc("gain trim", `ACF_REG_SGAIN, 3, 32'h89ABCD);
    cal_offset_new <= 24'h0000AA;
    cal_gain_new <= 24'h765432;
    cal_store <= 1'b1;
    @(posedge clk_sys);
    cal_store <= 1'b0;
    rdc("user offset", `ACF_REG_SOFF, 3, 32'h123456);
    cal_readback_select <= 1'b0;
    conv_valid <= 1'b1; // Conversions run during internal readback
    rdc("internal offset", `ACF_REG_SOFF, 3, 32'h0000AA);
    rdc("internal gain", `ACF_REG_SGAIN, 3, 32'h765432);
    conv_valid <= 1'b0;
    cal_readback_select <= 1'b1;
    reset_dut;
    $display("test trims done");
    host.wr(`ACF_REG_ODIR, 32'h2D, 1);
    out_is(6'h2D);
    host.wr(`ACF_REG_ODIR, 32'h00, 1);
    out_is(6'h00);
    seq_mode <= 3'h2;
    host.wr(`ACF_REG_ODIR, 32'h2D, 1);
    out_is(6'h2D);
    sleep <= 1'b1;
    repeat (2) @(posedge clk_sys);
    out_is(6'h00);
    sleep <= 1'b0;
    repeat (2) @(posedge clk_sys);
    out_is(6'h2D);
    for (int m = 3; m < 5; m++) begin
      seq_mode <= m[2:0];
      host.wr(`ACF_REG_ODIR, 32'h11, 1);
      out_is(6'h2D);
    end
    rdc("direct locked", `ACF_REG_ODIR, 1, 32'h2D);
    seq_mode <= 3'h1;
    self_cal_busy <= 1'b1;
    host.wr(`ACF_REG_ODIR, 32'h07, 1);
    out_is(6'h07);
    self_cal_busy <= 1'b0;
    host.wr(`ACF_REG_QHEAD, 32'hFFFFFFFF, 4);
    rdc("queue write", `ACF_REG_QHEAD, 4, 32'h0);
    $display("test direct outputs done");
    host.wr(`ACF_REG_SOFF, 32'h000010, 3);
    for (int i = 0; i < 8; i++) begin
      host.wr(`ACF_REG_SGAIN, {8'h00, t_gain[i]}, 3);
      {unipolar, fmt, skip_self_offset, skip_self_gain, skip_system_offset} <= t_ctl[i];
      conv(t_in[i], i[2:0]);
    end
    repeat (8) @(posedge clk_sys);
    check("level", {25'h0, fifo_level}, 32'h8);
    for (int i = 0; i < 8; i++)
      rdc("entry", `ACF_REG_QHEAD, 4, {4'h0, i[2:0], t_oor[i], t_res[i]});
    check("drained", {25'h0, fifo_level}, 32'h0);
    $display("test correction path done");
    {unipolar, fmt, skip_self_offset, skip_self_gain, skip_system_offset} <= 5'h07;
    // Half-scale system gain alone: 0x200 becomes 0x100 on channel 2
    skip_system_gain <= 1'b0;
    conv(24'h000200, 3'h2);
    repeat (8) @(posedge clk_sys);
    rdc("system gain", `ACF_REG_QHEAD, 4, 32'h04000100);
    skip_system_gain <= 1'b1;
    for (int i = 0; i < 65; i++) conv(i[23:0], 3'h5);
    repeat (8) @(posedge clk_sys);
    check("level full", {25'h0, fifo_level}, 32'h40);
    for (int i = 1; i < 65; i++)
      rdc("overwrite", `ACF_REG_QHEAD, 4, {i == 64, 3'h0, 3'h5, 1'b0, i[23:0]});
    check("host nacks", host.nacks, 32'h0);
    $display("test overflow done");
    report_and_stop;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
